/* File: src/serial_cmd_pkg.sv */
// Constants, field layouts and carrier types for the serial command port.
// Assumes two includers: the serial command port top module and the self-checking bench.

package serial_cmd_pkg;

    localparam int WORD_BITS = 16;
    localparam int CNT_BITS = 4;
    localparam int PAYLOAD_BITS = 10;
    localparam int MISC_BITS = 8;

    // Command word field positions
    localparam int WD_POS = 15;
    localparam int PAR_POS = 14;
    localparam int BANK_POS = 13;
    localparam int ADDR_MSB = 12;
    localparam int ADDR_LSB = 10;
    localparam int PAYLOAD_MSB = 9;

    // Register addresses inside a bank
    localparam logic [2:0] ADDR_STAT = 3'h0;
    localparam logic [2:0] ADDR_PWM = 3'h1;
    localparam logic [2:0] ADDR_CONF = 3'h2;
    localparam logic [2:0] ADDR_OCR = 3'h4;
    localparam logic [2:0] ADDR_RETRY = 3'h5;
    localparam logic [2:0] ADDR_GCR = 3'h6;
    localparam logic [2:0] ADDR_CAL = 3'h7;

    // Payload bit positions
    localparam int ON_POS = 8;
    localparam int OFP_POS = 8;
    localparam int TH_EN_POS = 5;
    localparam int TEMPW_POS = 0;

    // Readback selector of the fault register
    localparam logic [3:0] FAULT_SEL = 4'hE;

    // Reset values
    localparam logic [PAYLOAD_BITS-1:0] CFG_RESET = 10'h000;
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [CNT_BITS-1:0] CNT_RESET = 4'h0;
    localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;

    typedef struct packed {
        logic wd;
        logic par;
        logic bank;
        logic [2:0] addr;
        logic [PAYLOAD_BITS-1:0] payload;
    } cmd_word_t;

    typedef struct packed {
        logic [1:0] out_high;
        logic temp_hot;
        logic normal_mode;
        logic [MISC_BITS-1:0] misc;
    } plant_in_t;

    typedef struct packed {
        cmd_word_t last_word;
        logic [CNT_BITS-1:0] bit_cnt;
        logic seen_word;
        logic parity_err;
    } link_frame_t;

endpackage

/* File: src/serial_cmd_port.sv */
// Serial command port of a dual-channel high side switch, device side.
// Assumes an external master drives SCLK, CS_N and SI; analog sensing is outside.
`timescale 1ns/1ps

module serial_cmd_port
    import serial_cmd_pkg::*;
#(
    parameter bit SAMPLE_RISING = 1'b1
)
(
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic SI,
    output logic SO_O,
    output logic SO_OE,
    input wire logic [1:0] OUT_HIGH,
    input wire logic TEMP_HOT,
    input wire logic NORMAL_MODE,
    input wire logic [7:0] STATUS_MISC,
    output logic [1:0] ON_CMD,
    output logic [1:0] OFFSET_POL,
    output logic TEMP_PREWARN,
    output logic FRAME_REJECT
);

    // ------------------------------------------------------------------
    // Link clocks
    // ------------------------------------------------------------------
    logic in_clk;
    logic out_clk;
    logic frame_clr;

    assign in_clk = SAMPLE_RISING ? SCLK : ~SCLK;
    assign out_clk = ~in_clk;
    assign frame_clr = CS_N | ~RESET_N;

    // ------------------------------------------------------------------
    // Link domain: input shifter
    // ------------------------------------------------------------------
    logic first_in_reg;
    logic [WORD_BITS-1:0] in_shift_reg;
    logic [WORD_BITS-1:0] in_shift_next;
    logic [CNT_BITS-1:0] bit_cnt_reg;
    logic [CNT_BITS-1:0] bit_cnt_next;
    cmd_word_t last_word_reg;
    logic seen_word_reg;
    logic parity_err_reg;
    logic frame_tog_reg;

    // Marks that the next sampling edge is the first of a frame
    always_ff @(posedge in_clk or posedge frame_clr)
    begin
        if (frame_clr)
            first_in_reg <= 1'b1;
        else
            first_in_reg <= 1'b0;
    end

    assign in_shift_next = {in_shift_reg[WORD_BITS-2:0], SI};
    assign bit_cnt_next = first_in_reg ? {{(CNT_BITS-1){1'b0}}, 1'b1} : bit_cnt_reg + 1'b1;

    always_ff @(posedge in_clk or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            in_shift_reg <= WORD_RESET;
            bit_cnt_reg <= CNT_RESET;
        end
        else
        begin
            in_shift_reg <= in_shift_next;
            bit_cnt_reg <= bit_cnt_next;
        end
    end

    // Word completion and parity, kept until the first sampling edge of the next frame
    always_ff @(posedge in_clk or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            last_word_reg <= cmd_word_t'(WORD_RESET);
            seen_word_reg <= 1'b0;
            parity_err_reg <= 1'b0;
        end
        else if (bit_cnt_next == CNT_RESET)
        begin
            last_word_reg <= cmd_word_t'(in_shift_next);
            seen_word_reg <= 1'b1;
            parity_err_reg <= parity_err_reg | (^in_shift_next);
        end
        else if (first_in_reg)
        begin
            seen_word_reg <= 1'b0;
            parity_err_reg <= 1'b0;
        end
    end

    // Flips once per frame so an empty select pulse is not taken as a frame
    always_ff @(posedge in_clk or negedge RESET_N)
    begin
        if (!RESET_N)
            frame_tog_reg <= 1'b0;
        else if (first_in_reg)
            frame_tog_reg <= ~frame_tog_reg;
    end

    // ------------------------------------------------------------------
    // Link domain: output shifter
    // ------------------------------------------------------------------
    logic first_out_reg;
    logic [WORD_BITS-1:0] out_shift_reg;
    logic [WORD_BITS-1:0] so_snap_reg;

    always_ff @(posedge out_clk or posedge frame_clr)
    begin
        if (frame_clr)
            first_out_reg <= 1'b1;
        else
            first_out_reg <= 1'b0;
    end

    // After the first word the received bits come back out, 16 bits late
    always_ff @(posedge out_clk or negedge RESET_N)
    begin
        if (!RESET_N)
            out_shift_reg <= WORD_RESET;
        else if (first_out_reg)
            out_shift_reg <= {so_snap_reg[WORD_BITS-2:0], in_shift_reg[0]};
        else
            out_shift_reg <= {out_shift_reg[WORD_BITS-2:0], in_shift_reg[0]};
    end

    // Bit 15 must stand before any clock edge, hence the snapshot bypass
    assign SO_O = first_out_reg ? so_snap_reg[WORD_BITS-1] : out_shift_reg[WORD_BITS-1];
    assign SO_OE = ~frame_clr;

    // ------------------------------------------------------------------
    // System domain: synchronisers
    // ------------------------------------------------------------------
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic cs_s3_reg;
    logic tog_s1_reg;
    logic tog_s2_reg;
    logic tog_seen_reg;
    plant_in_t plant_s1_reg;
    plant_in_t plant_reg;
    plant_in_t plant_raw;
    logic cs_rise;

    assign plant_raw = '{out_high: OUT_HIGH, temp_hot: TEMP_HOT,
                         normal_mode: NORMAL_MODE, misc: STATUS_MISC};

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            cs_s1_reg <= 1'b1;
            cs_s2_reg <= 1'b1;
            cs_s3_reg <= 1'b1;
            tog_s1_reg <= 1'b0;
            tog_s2_reg <= 1'b0;
        end
        else
        begin
            cs_s1_reg <= CS_N;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
            tog_s1_reg <= frame_tog_reg;
            tog_s2_reg <= tog_s1_reg;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            plant_s1_reg <= '0;
            plant_reg <= '0;
        end
        else
        begin
            plant_s1_reg <= plant_raw;
            plant_reg <= plant_s1_reg;
        end
    end

    assign cs_rise = cs_s2_reg & ~cs_s3_reg;

    // ------------------------------------------------------------------
    // System domain: frame evaluation
    // ------------------------------------------------------------------
    link_frame_t frame;
    logic new_frame;
    logic frame_ok;
    logic write_en;

    // Link registers are still once select is high, so they are read directly
    assign frame = '{last_word: last_word_reg, bit_cnt: bit_cnt_reg,
                     seen_word: seen_word_reg, parity_err: parity_err_reg};
    assign new_frame = cs_rise & (tog_s2_reg != tog_seen_reg);
    assign frame_ok = frame.seen_word & (frame.bit_cnt == CNT_RESET) & ~frame.parity_err;
    assign write_en = new_frame & frame_ok;

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            tog_seen_reg <= 1'b0;
        else if (cs_rise)
            tog_seen_reg <= tog_s2_reg;
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            FRAME_REJECT <= 1'b0;
        else
            FRAME_REJECT <= new_frame & ~frame_ok;
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [PAYLOAD_BITS-1:0] cfg_mem [16];

    // General configuration exists once, whichever bank the word names
    function automatic logic [3:0] cfg_index(input cmd_word_t w);
        if (w.addr == ADDR_GCR)
            return {1'b0, ADDR_GCR};
        return {w.bank, w.addr};
    endfunction

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            for (int i = 0; i < 16; i++)
                cfg_mem[i] <= CFG_RESET;
        end
        else if (write_en && frame.last_word.addr != ADDR_STAT)
        begin
            cfg_mem[cfg_index(frame.last_word)] <= frame.last_word.payload;
        end
    end

    // ------------------------------------------------------------------
    // Readback selection and status
    // ------------------------------------------------------------------
    logic [3:0] rd_sel_reg;
    logic wd_seen_reg;
    logic parity_flag_reg;
    logic prewarn_reg;
    logic [WORD_BITS-1:0] readback;

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rd_sel_reg <= SEL_RESET;
            wd_seen_reg <= 1'b0;
        end
        else if (write_en)
        begin
            wd_seen_reg <= frame.last_word.wd;
            if (frame.last_word.addr == ADDR_STAT)
                rd_sel_reg <= {frame.last_word.bank, frame.last_word.payload[2:0]};
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            parity_flag_reg <= 1'b0;
        else if (new_frame && frame.seen_word)
            parity_flag_reg <= frame.parity_err;
    end

    always_comb
    begin
        readback = {wd_seen_reg, parity_flag_reg, rd_sel_reg, CFG_RESET};
        if (rd_sel_reg[2:0] == ADDR_STAT)
            readback[PAYLOAD_MSB:0] = {plant_reg.misc, plant_reg.out_high};
        else if (rd_sel_reg == FAULT_SEL)
            readback[TEMPW_POS] = prewarn_reg;
        else
            readback[PAYLOAD_MSB:0] = cfg_mem[rd_sel_reg];
    end

    // Frozen while select is low so the link side sees a steady word
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            so_snap_reg <= WORD_RESET;
        else if (cs_s2_reg && !cs_rise)
            so_snap_reg <= readback;
    end

    // ------------------------------------------------------------------
    // Temperature prewarning
    // ------------------------------------------------------------------
    logic fault_read;

    assign fault_read = new_frame & frame.seen_word & (rd_sel_reg == FAULT_SEL);

    // Setting wins over a clearing read in the same cycle
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            prewarn_reg <= 1'b0;
        else if (plant_reg.normal_mode && plant_reg.temp_hot)
            prewarn_reg <= 1'b1;
        else if (fault_read && !plant_reg.temp_hot)
            prewarn_reg <= 1'b0;
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
            TEMP_PREWARN <= 1'b0;
        else
            TEMP_PREWARN <= prewarn_reg;
    end

    // ------------------------------------------------------------------
    // Per-channel controls and held offset polarity
    // ------------------------------------------------------------------
    logic th_en;

    assign th_en = cfg_mem[{1'b0, ADDR_GCR}][TH_EN_POS];

    for (genvar ch = 0; ch < 2; ch++)
    begin : g_chan
        logic held_ofp_reg;
        logic live_ofp;

        assign live_ofp = cfg_mem[{ch[0], ADDR_RETRY}][OFP_POS];

        always_ff @(posedge SYS_CLK or negedge RESET_N)
        begin
            if (!RESET_N)
            begin
                held_ofp_reg <= 1'b0;
            end
            else
            begin
                // Tracks while on, so the value left at switch-off is the one in force
                if (plant_reg.out_high[ch])
                    held_ofp_reg <= live_ofp;
            end
        end

        always_ff @(posedge SYS_CLK or negedge RESET_N)
        begin
            if (!RESET_N)
            begin
                OFFSET_POL[ch] <= 1'b0;
                ON_CMD[ch] <= 1'b0;
            end
            else
            begin
                OFFSET_POL[ch] <= (th_en && !plant_reg.out_high[ch]) ? held_ofp_reg : live_ofp;
                ON_CMD[ch] <= cfg_mem[{ch[0], ADDR_PWM}][ON_POS];
            end
        end
    end

endmodule // serial_cmd_port

/* File: test/serial_cmd_port_checker.sv */
// Concurrent checks on the serial command port top-level pins.
// Assumes SYS_CLK runs freely and RESET_N is asynchronous, active low.
`timescale 1ns/1ps

module serial_cmd_port_checker
(
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic CS_N,
    input wire logic SO_OE,
    input wire logic TEMP_HOT,
    input wire logic NORMAL_MODE,
    input wire logic [1:0] ON_CMD,
    input wire logic TEMP_PREWARN,
    input wire logic FRAME_REJECT
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);

    sequence hot_seq;
        (NORMAL_MODE && TEMP_HOT) [*4];
    endsequence

    sequence quiet_seq;
        (!CS_N) [*6];
    endsequence

    sequence still_seq;
        $stable(ON_CMD) ##1 $stable(ON_CMD);
    endsequence

    chk_oe_follow: assert property (SO_OE == !CS_N)
        else $error("Output enable differs from chip select");
    chk_reject_pulse: assert property (FRAME_REJECT |=> !FRAME_REJECT)
        else $error("Reject pulse longer than one cycle");
    chk_reject_idle: assert property (FRAME_REJECT |-> CS_N && $past(CS_N, 3))
        else $error("Reject pulse without a finished frame");
    chk_reject_keep: assert property (FRAME_REJECT |-> still_seq)
        else $error("Rejected frame changed channel commands");
    chk_on_quiet: assert property (quiet_seq |=> $stable(ON_CMD))
        else $error("Channel command changed inside a frame");
    chk_on_after_end: assert property (
        $changed(ON_CMD) |-> $past(CS_N, 1) && $past(CS_N, 3))
        else $error("Channel command changed without a frame end");
    chk_prewarn_set: assert property (hot_seq |-> ##[0:4] TEMP_PREWARN)
        else $error("Prewarning flag not raised when hot");
    chk_prewarn_clear: assert property ($fell(TEMP_PREWARN) |-> CS_N && !TEMP_HOT)
        else $error("Prewarning flag cleared while hot or in a frame");
endmodule // serial_cmd_port_checker

bind serial_cmd_port serial_cmd_port_checker i_chk
(
    .SYS_CLK(SYS_CLK),
    .RESET_N(RESET_N),
    .CS_N(CS_N),
    .SO_OE(SO_OE),
    .TEMP_HOT(TEMP_HOT),
    .NORMAL_MODE(NORMAL_MODE),
    .ON_CMD(ON_CMD),
    .TEMP_PREWARN(TEMP_PREWARN),
    .FRAME_REJECT(FRAME_REJECT)
);

/* File: test/spi_master_model.sv */
// Serial master model for the command port link pins.
// Assumes the port samples on the clock rise and shifts out on the fall.
`timescale 1ns/1ps

module spi_master_model
(
    output logic SCLK,
    output logic CS_N,
    output logic SI,
    input wire logic SO_O,
    input wire logic SO_OE
);
    initial
    begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        SI = 1'b0;
    end

    // Sends n bits of w, MSB first; clock stands low outside frames
    task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] so);
        so = '0;
        // Keeps every link edge off the system clock rising edges when the task is called on one
        #1;
        CS_N = 1'b0;
        #40;
        for (int i = n - 1; i >= 0; i--)
        begin
            SI = w[i];
            #80;
            SCLK = 1'b1;
            so = {so[30:0], SO_OE ? SO_O : 1'bx};
            #80;
            SCLK = 1'b0;
        end
        #40;
        CS_N = 1'b1;
        SI = ~SI;
        #100;
    endtask
endmodule // spi_master_model

/* File: test/serial_cmd_port_tb_top.sv */
// Self-checking bench for the serial command port.
// Assumes the master model drives the link at a 160 ns clock period.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        n_tests++; \
        if ((g) !== (e)) \
        begin \
            err_total++; \
            $display("Error %s expected %h seen %h", nm, e, g); \
        end \
    end

module serial_cmd_port_tb_top import serial_cmd_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic temp_hot = 1'b0;
    logic normal_mode = 1'b0;
    logic [1:0] out_high = 2'b00;
    logic [7:0] misc = 8'h00;
    logic wd = 1'b0;
    logic sclk, cs_n, si, so_o, so_oe, temp_prewarn, frame_reject;
    logic [1:0] on_cmd, offset_pol;
    logic [31:0] so;
    int err_total = 0;
    int n_tests = 0;
    int rej_cnt = 0;

    always #2 clk = ~clk;

    // Counts reject pulses mid-cycle, away from the edge that launches them
    always @(negedge clk)
    begin
        if (frame_reject === 1'b1)
            rej_cnt++;
    end

    serial_cmd_port i_dut
    (
        .SYS_CLK(clk),
        .RESET_N(rst_n),
        .SCLK(sclk),
        .CS_N(cs_n),
        .SI(si),
        .SO_O(so_o),
        .SO_OE(so_oe),
        .OUT_HIGH(out_high),
        .TEMP_HOT(temp_hot),
        .NORMAL_MODE(normal_mode),
        .STATUS_MISC(misc),
        .ON_CMD(on_cmd),
        .OFFSET_POL(offset_pol),
        .TEMP_PREWARN(temp_prewarn),
        .FRAME_REJECT(frame_reject)
    );

    spi_master_model i_m
    (
        .SCLK(sclk),
        .CS_N(cs_n),
        .SI(si),
        .SO_O(so_o),
        .SO_OE(so_oe)
    );

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    function automatic logic [15:0] mk(logic w, logic b, logic [2:0] a, logic [9:0] p);
        mk = {w, ^{w, b, a, p}, b, a, p};
    endfunction

    task automatic cmd(input logic b, input logic [2:0] a, input logic [9:0] p);
        i_m.xfer({16'h0000, mk(wd, b, a, p)}, 16, so);
        wd = ~wd;
    endtask

    task automatic note(input string s);
        $display("Test %s done", s);
    endtask

    task automatic end_of_test;
        $display("Checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        cmd(1'b0, ADDR_PWM, 10'h100);
        `CHK("on_cmd", 2'b01, on_cmd)
        i_m.xfer({16'h0000, mk(wd, 1'b1, ADDR_PWM, 10'h100) ^ 16'h4000}, 16, so);
        `CHK("on_cmd", 2'b01, on_cmd)
        i_m.xfer({15'h0000, mk(wd, 1'b1, ADDR_PWM, 10'h100), 1'b0}, 17, so);
        `CHK("on_cmd", 2'b01, on_cmd)
        `CHK("reject", 2, rej_cnt)
        note("refuse");
        i_m.xfer({mk(wd, 1'b0, ADDR_PWM, 10'h000), mk(~wd, 1'b1, ADDR_PWM, 10'h100)}, 32, so);
        `CHK("on_cmd", 2'b11, on_cmd)
        `CHK("echo", mk(wd, 1'b0, ADDR_PWM, 10'h000), so[15:0])
        note("chain");
        @(posedge clk);
        misc <= 8'hA5;
        out_high <= 2'b10;
        cmd(1'b0, ADDR_STAT, 10'h000);
        cmd(1'b0, ADDR_STAT, 10'h000);
        `CHK("status", {wd, 1'b0, 4'h0, 8'hA5, 2'b10}, so[15:0])
        note("status");
        cmd(1'b1, ADDR_RETRY, 10'h100);
        `CHK("offset_pol", 2'b10, offset_pol)
        cmd(1'b0, ADDR_GCR, 10'h020);
        cmd(1'b0, ADDR_RETRY, 10'h100);
        @(posedge clk);
        out_high <= 2'b11;
        repeat (8) @(posedge clk);
        out_high <= 2'b10;
        repeat (8) @(posedge clk);
        cmd(1'b0, ADDR_RETRY, 10'h000);
        `CHK("held", 2'b11, offset_pol)
        @(posedge clk);
        out_high <= 2'b11;
        repeat (8) @(posedge clk);
        `CHK("live", 2'b10, offset_pol)
        note("offset");
        @(posedge clk);
        normal_mode <= 1'b1;
        temp_hot <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK("prewarn", 1'b1, temp_prewarn)
        `CHK("on_cmd", 2'b11, on_cmd)
        temp_hot <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK("prewarn", 1'b1, temp_prewarn)
        cmd(1'b1, ADDR_STAT, 10'h006);
        cmd(1'b0, ADDR_STAT, 10'h000);
        `CHK("fault", 1'b1, so[0])
        `CHK("prewarn", 1'b0, temp_prewarn)
        note("prewarn");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK("rst_on_cmd", 2'b00, on_cmd)
        `CHK("rst_offset_pol", 2'b00, offset_pol)
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        cmd(1'b1, ADDR_PWM, 10'h100);
        `CHK("on_cmd", 2'b10, on_cmd)
        `CHK("reject", 2, rej_cnt)
        note("reset");
        end_of_test;
    end

    initial
    begin
        #100000;
        err_total++;
        $display("Watchdog expired");
        end_of_test;
    end
endmodule // serial_cmd_port_tb_top
